// ---- src/standby_irq_map.svh ----
`ifndef STANDBY_IRQ_MAP_SVH
`define STANDBY_IRQ_MAP_SVH
`define BOOT_ADDR        32'h07ffffff
`define NUM_SRC          57
`define NUM_LEVELS       16
`define NUM_WAKE         7
`define WAKE_BASE        50
`define NUM_ASYNC        31
`define STBY_DIV         8'h1b
`define MODE_EDGE        1'b1
`define MODE_LEVEL       1'b0
`endif

// ---- src/standby_irq_pkg.sv ----
package standby_irq_pkg;
   typedef enum logic [2:0] {
      ST_RUN     = 3'b001,
      ST_STANDBY = 3'b010,
      ST_WAKE    = 3'b100
   } pm_state_t;
   typedef logic [3:0] level_t;
endpackage

// ---- src/src_sync.sv ----
`timescale 1ns/1ns
module src_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] sync_d;

   always_comb
   begin
      meta_d = async_in;
      sync_d = meta_q;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         meta_q <= '0;
         sync_q <= '0;
      end
      else
      begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_out = sync_q;
endmodule

// ---- src/level_irq_router.sv ----
`timescale 1ns/1ns
`include "standby_irq_map.svh"
module level_irq_router
   import standby_irq_pkg::*;
#(
   parameter int NUM_SRC    = `NUM_SRC,
   parameter int NUM_LEVELS = `NUM_LEVELS,
   parameter int NUM_UNITS  = 8
) (
   input  wire logic                    clk,
   input  wire logic                    reset,
   input  wire logic [NUM_SRC-1:0]      src_irq,
   input  wire logic [NUM_SRC-1:0]      src_is_async,
   input  wire logic [NUM_SRC-1:0]      src_edge_mode,
   input  wire logic [NUM_SRC*4-1:0]    src_level,
   input  wire logic [NUM_SRC-1:0]      src_clear,
   input  wire logic                    standby_req,
   input  wire logic [NUM_UNITS-1:0]    unit_power_off,
   input  wire logic [NUM_UNITS-1:0]    unit_soft_reset,
   output logic      [NUM_LEVELS-1:0]   level_req,
   output logic      [NUM_SRC-1:0]      src_pending,
   output logic                         cpu_clk_en,
   output logic                         ir_clk_en,
   output logic                         rtc_clk_en,
   output logic                         adc_clk_en,
   output logic                         slow_tick,
   output logic      [NUM_UNITS-1:0]    unit_clk_en,
   output logic      [NUM_UNITS-1:0]    unit_reset,
   output logic      [31:0]             boot_addr,
   output logic                         boot_fetch,
   output logic                         in_standby
);
   logic [NUM_SRC-1:0] synced;
   logic [NUM_SRC-1:0] sel_q;
   logic [NUM_SRC-1:0] sel_d;
   logic [NUM_SRC-1:0] prev_q;
   logic [NUM_SRC-1:0] prev_d;
   logic [NUM_SRC-1:0] pend_q;
   logic [NUM_SRC-1:0] pend_d;
   logic [NUM_SRC-1:0] event_w;
   logic [NUM_LEVELS-1:0] lvl_q;
   logic [NUM_LEVELS-1:0] lvl_d;
   pm_state_t state_q;
   pm_state_t state_d;
   logic [7:0] div_q;
   logic [7:0] div_d;
   logic tick_q;
   logic tick_d;
   logic boot_q;
   logic boot_d;
   logic [31:0] addr_q;
   logic [31:0] addr_d;
   logic wake_any;
   level_t src_lvl [NUM_SRC];

   // two-stage synchroniser
   // async sources take two extra cycles before the select register
   src_sync #(
      .WIDTH (NUM_SRC)
   ) u_sync (
      .clk      (clk),
      .reset    (reset),
      .async_in (src_irq),
      .sync_out (synced)
   );

   genvar g;
   generate
      for (g = 0; g < NUM_SRC; g++)
      begin : g_src
         // pick resynchronised copy for async sources
         assign sel_d[g] = src_is_async[g] ? synced[g] : src_irq[g];
         // per-source level field
         assign src_lvl[g] = src_level[g*4 +: 4];
         // prev_q resets low like an idle source; a source held high through reset still reads as an edge
         // edge or level detect
         assign event_w[g] = (src_edge_mode[g] == `MODE_EDGE) ? (sel_q[g] & ~prev_q[g])
                                                              : sel_q[g];
      end
   endgenerate

   // an event in the clear cycle is kept, so no request is lost
   // pending set wins over clear
   always_comb
   begin
      prev_d = sel_q;
      pend_d = (pend_q & ~src_clear) | event_w;
   end

   always_comb
   begin
      lvl_d = '0;
      for (int i = 0; i < NUM_SRC; i++)
      begin
         if (pend_q[i])
         begin
            lvl_d[src_lvl[i]] = 1'b1;
         end
      end
   end

   // seven wake sources in the peripheral group
   // converter, infrared, rtc and four externals
   assign wake_any = |pend_q[`WAKE_BASE +: `NUM_WAKE];

   // standby is refused while a wake source is pending, or the cpu
   // would stop with nothing left to restart it
   // standby entry and wake-up
   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         ST_RUN:
         begin
            if (standby_req && !wake_any)
            begin
               state_d = ST_STANDBY;
            end
         end
         ST_STANDBY:
         begin
            if (wake_any)
            begin
               state_d = ST_WAKE;
            end
         end
         ST_WAKE:
         begin
            state_d = ST_RUN;
         end
         default:
         begin
            state_d = ST_RUN;
         end
      endcase
   end

   // free running, so the standby units see a steady rate
   // divided slow clock tick from oscillator
   always_comb
   begin
      if (div_q == `STBY_DIV - 8'h01)
      begin
         div_d  = 8'h00;
         tick_d = 1'b1;
      end
      else
      begin
         div_d  = div_q + 8'h01;
         tick_d = 1'b0;
      end
   end

   // boot_fetch drops one cycle after reset leaves
   // boot fetch from flash once after reset
   always_comb
   begin
      boot_d = 1'b0;
      addr_d = `BOOT_ADDR;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         sel_q   <= '0;
         prev_q  <= '0;
         pend_q  <= '0;
         lvl_q   <= '0;
         state_q <= ST_RUN;
         div_q   <= 8'h00;
         tick_q  <= 1'b0;
         boot_q  <= 1'b1;
         addr_q  <= `BOOT_ADDR;
      end
      else
      begin
         sel_q   <= sel_d;
         prev_q  <= prev_d;
         pend_q  <= pend_d;
         lvl_q   <= lvl_d;
         state_q <= state_d;
         div_q   <= div_d;
         tick_q  <= tick_d;
         boot_q  <= boot_d;
         addr_q  <= addr_d;
      end
   end

   assign level_req   = lvl_q;
   assign src_pending = pend_q;
   assign in_standby  = (state_q == ST_STANDBY);
   // gate everything but restart logic in standby
   assign cpu_clk_en  = (state_q != ST_STANDBY);
   // infrared, rtc and converter stay clocked
   assign ir_clk_en   = 1'b1;
   assign rtc_clk_en  = 1'b1;
   assign adc_clk_en  = 1'b1;
   assign slow_tick   = tick_q;
   // soft resets pass straight through, they are local to each unit
   // per-unit power-off and soft reset
   assign unit_clk_en = (state_q == ST_STANDBY) ? '0 : ~unit_power_off;
   assign unit_reset  = unit_soft_reset;
   assign boot_addr   = addr_q;
   assign boot_fetch  = boot_q;
endmodule

// ---- bench/level_irq_router_properties.sv ----
`timescale 1ns/1ns
module level_irq_router_properties (
   input wire logic        clk,
   input wire logic        reset,
   input wire logic [56:0] src_irq,
   input wire logic [56:0] src_is_async,
   input wire logic [56:0] src_edge_mode,
   input wire logic [56:0] src_pending,
   input wire logic        cpu_clk_en,
   input wire logic        ir_clk_en,
   input wire logic        rtc_clk_en,
   input wire logic        adc_clk_en,
   input wire logic        slow_tick,
   input wire logic [7:0]  unit_clk_en,
   input wire logic [31:0] boot_addr,
   input wire logic        boot_fetch,
   input wire logic        in_standby
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (reset);
   boot_addr_a: assert property (boot_addr == 32'h07ffffff)
      else $error("boot address wrong");
   boot_fetch_a: assert property ($fell(reset) |-> boot_fetch ##1 !boot_fetch)
      else $error("boot fetch window wrong");
   standby_gate_a: assert property (in_standby |-> !cpu_clk_en && unit_clk_en == 8'h0)
      else $error("clock running in standby");
   keep_clocks_a: assert property (ir_clk_en && rtc_clk_en && adc_clk_en)
      else $error("standby unit clock stopped");
   slow_tick_a: assert property (slow_tick |=> !slow_tick ##26 slow_tick)
      else $error("slow tick period wrong");
   wake_restart_a: assert property (in_standby && |src_pending[56:50] |-> ##[1:2] cpu_clk_en)
      else $error("wake did not restart cpu clock");
   wake_refuse_a: assert property (!in_standby && |src_pending[56:50] |=> !in_standby)
      else $error("standby entered with wake pending");
   sync_pend_a: assert property (
      !src_is_async[0] && !src_edge_mode[0] && src_irq[0] |-> ##2 src_pending[0])
      else $error("sync source not pending in time");
endmodule

// ---- bench/irq_src_model.sv ----
`timescale 1ns/1ns
module irq_src_model (
   input wire logic        clk,
   input wire logic [56:0] want,
   input wire logic [56:0] is_async,
   output logic     [56:0] src_irq
);
   logic [56:0] s_q, a_q;
   // async sources move off the edge
   always @(posedge clk) s_q <= want & ~is_async;
   always @(negedge clk) a_q <= want & is_async;
   assign src_irq = s_q | a_q;
endmodule

// ---- bench/test_level_irq_router.sv ----
`timescale 1ns/1ns
module test_level_irq_router;
   logic         clk = 0;
   logic         reset = 1;
   logic         sreq = 0;
   logic [56:0]  want = '0, asy = '0, edg = '0, clr = '0, src;
   logic [227:0] lvl = '0;
   logic [7:0]   pwr = '0, srst = '0, uce, urst;
   logic [15:0]  lreq, exp_q[$];
   logic [16:0]  r = 17'h1328e;
   logic         cpu_en, stby;
   int           n_errors = 0, checks_done = 0, cyc = 0;
   initial forever #10 clk = ~clk;
   irq_src_model src_m (.clk(clk), .want(want), .is_async(asy), .src_irq(src));
   level_irq_router uut (.clk(clk), .reset(reset), .src_irq(src), .src_is_async(asy),
      .src_edge_mode(edg), .src_level(lvl), .src_clear(clr), .standby_req(sreq),
      .unit_power_off(pwr), .unit_soft_reset(srst), .level_req(lreq), .src_pending(),
      .cpu_clk_en(cpu_en), .ir_clk_en(), .rtc_clk_en(), .adc_clk_en(), .slow_tick(),
      .unit_clk_en(uce), .unit_reset(urst), .boot_addr(), .boot_fetch(), .in_standby(stby));
   function automatic logic [16:0] nx(input logic [16:0] s);
      return {s[15:0], s[16] ^ s[13]};
   endfunction
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wrap_up;
      if (n_errors == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // raise one source, let the monitor see its level, then clear it
   task automatic fire(input int i, input logic a, input logic e);
      @(posedge clk) #2;
      asy[i] = a;
      edg[i] = e;
      exp_q.push_back(16'h1 << lvl[4*i+:4]);
      want[i] = 1;
      repeat (8) @(posedge clk);
      chk(exp_q.size(), 0);
      #2 sreq = (i >= 50);
      @(posedge clk) #2 chk({stby, cpu_en}, 2'b01);
      sreq = 0;
      want[i] = 0;
      repeat (4) @(posedge clk);
      #2 clr[i] = 1;
      @(posedge clk) #2 clr[i] = 0;
      repeat (3) @(posedge clk);
      #2 chk(lreq, 16'h0);
   endtask
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         n_errors++;
         wrap_up;
      end
      else if (lreq !== 16'h0 && exp_q.size() > 0)
      begin
         chk(lreq, exp_q.pop_front());
      end
   end
   initial
   begin
      for (int i = 0; i < 57; i++)
      begin
         r = nx(r);
         lvl[4*i+:4] = r[3:0];
      end
      repeat (4) @(posedge clk);
      #2 reset = 0;
      fire(0, 0, 0);
      for (int k = 0; k < 12; k++)
      begin
         r = nx(r);
         pwr = r[7:0];
         srst = r[15:8];
         fire(r % 57, r[5], r[6]);
         chk({uce, urst}, {~pwr, srst});
      end
      for (int w = 50; w < 57; w++)
      begin
         sreq = 1;
         repeat (3) @(posedge clk);
         #2 chk({stby, cpu_en, uce}, {2'b10, 8'h0});
         sreq = 0;
         fire(w, w[0], w[1]);
         chk({stby, cpu_en}, 2'b01);
      end
      wrap_up;
   end
endmodule
bind level_irq_router level_irq_router_properties chk_u (.clk(clk), .reset(reset),
   .src_irq(src_irq), .src_is_async(src_is_async), .src_edge_mode(src_edge_mode),
   .src_pending(src_pending), .cpu_clk_en(cpu_clk_en), .ir_clk_en(ir_clk_en),
   .rtc_clk_en(rtc_clk_en), .adc_clk_en(adc_clk_en), .slow_tick(slow_tick),
   .unit_clk_en(unit_clk_en), .boot_addr(boot_addr), .boot_fetch(boot_fetch),
   .in_standby(in_standby));
